// [rtl/ddp_pkg.sv]
// Purpose: constants for the dual data pointer unit
// Assumes: special-function register bus of the core, 8-bit data
// Notes:   register offset in special-function space
package ddp_pkg;
  localparam logic [7:0] PTR_CTRL_ADDR   = 8'ha2;   // pointer_control_reg offset
  localparam int         SEL_BIT         = 0;       // pointer_select position
  localparam int         STUCK_BIT       = 2;       // always-zero position
  localparam int         FLAG_BIT        = 3;       // user_flag_bit position
  localparam logic       SEL_RESET       = 1'b0;
  localparam logic       FLAG_RESET      = 1'b0;    // undefined in hardware; zero here
  localparam logic [7:0] UPPER_RESET     = 8'h00;   // bits 7..4 and 1 kept, reset zero
  localparam logic [15:0] PTR_RESET      = 16'h0000;
  localparam int         INC_BYTES       = 2;       // encoded length of the increment
  localparam int         INC_OSC_CLOCKS  = 12;      // oscillator clocks of the increment
endpackage

// [rtl/ddp_pointer.sv]
// Purpose: one 16-bit data pointer with load, byte write and increment
// Assumes: caller gates every command by the pointer select
// Notes:   holds its value when no command is given
`timescale 1ns/1ps
module ddp_pointer (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // commands
  input  wire logic        load_i,
  input  wire logic [15:0] load_val_i,
  input  wire logic        wr_hi_i,
  input  wire logic        wr_lo_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        inc_i,
  // value
  output logic      [15:0] ptr_o
);
  logic [15:0] ptr_reg;
  logic [15:0] ptr_next;

  // next pointer value; unchanged without a command
  always_comb begin
    ptr_next = ptr_reg;
    if (load_i) begin
      ptr_next = load_val_i;
    end else if (inc_i) begin
      ptr_next = ptr_reg + 16'h0001;
    end else begin
      if (wr_hi_i) begin
        ptr_next[15:8] = wdata_i;
      end
      if (wr_lo_i) begin
        ptr_next[7:0] = wdata_i;
      end
    end
  end

  // pointer storage
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_reg <= ddp_pkg::PTR_RESET;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  assign ptr_o = ptr_reg;
endmodule

// [rtl/ddp_dual_pointer.sv]
// Purpose: dual 16-bit data pointer with select register
// Assumes: core drives single-cycle special-function and pointer commands
// Notes:   the increment of the control register arrives as one strobe
//
// Function
// - two independent 16-bit pointers hold addresses
// - control bit 0 selects the active pointer
// - bit 2 reads zero; increment keeps flag
// - increment toggles select, never forces it
// - reset clears select and stuck bit
// - increment is two-byte, twelve-clock pointer switch
// - external move drives high and low bytes
`timescale 1ns/1ps
module ddp_dual_pointer (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  // special-function register access
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        ctrl_inc_i,
  // pointer commands from the core
  input  wire logic        ptr_load_i,
  input  wire logic [15:0] ptr_load_val_i,
  input  wire logic        ptr_wr_hi_i,
  input  wire logic        ptr_wr_lo_i,
  input  wire logic        ptr_inc_i,
  input  wire logic        xmove_i,
  // results
  output logic      [7:0]  ctrl_rdata_o,
  output logic      [15:0] data_pointer_o,
  output logic      [7:0]  addr_hi_o,
  output logic      [7:0]  addr_lo_o,
  output logic             addr_valid_o
);
  logic       rst_s1_reg;
  logic       rst_n_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [15:0] ptr0;
  logic [15:0] ptr1;
  logic [15:0] sel_ptr;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [15:0] dp_reg;
  logic [15:0] dp_next;
  logic [15:0] xaddr_reg;
  logic [15:0] xaddr_next;
  logic       xval_reg;
  logic       xval_next;
  logic       ctrl_hit;
  logic       sel;

  // reset release through two flip-flops; entry is immediate, exit takes two
  // edges so that no register leaves reset on a metastable level
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // control register decode and the current select
  assign ctrl_hit = sfr_addr_i == ddp_pkg::PTR_CTRL_ADDR;
  assign sel      = ctrl_reg[ddp_pkg::SEL_BIT];

  // control register next value; an increment only inverts the select so the
  // flag and every other bit keep their value, and it wins over a write
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_hit && ctrl_inc_i) begin
      ctrl_next[ddp_pkg::SEL_BIT] = ~ctrl_reg[ddp_pkg::SEL_BIT];
    end else if (ctrl_hit && sfr_wr_i) begin
      ctrl_next = sfr_wdata_i;
    end
    ctrl_next[ddp_pkg::STUCK_BIT] = 1'b0;
  end

  // control register storage
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg <= {ddp_pkg::UPPER_RESET[7:4], ddp_pkg::FLAG_RESET, 1'b0,
                   ddp_pkg::UPPER_RESET[1], ddp_pkg::SEL_RESET};
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // one command strobe, passed on only to the pointer that the select names;
  // every command goes through the same gate so the idle pointer never moves
  function automatic logic ddp_steer(input logic cmd, input logic sel_now, input logic idx);
    return cmd && (sel_now == idx);
  endfunction

  // two pointers, commands steered to the selected one only
  ddp_pointer u_ptr0 (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_reg),
    .load_i     (ddp_steer(ptr_load_i, sel, 1'b0)),
    .load_val_i (ptr_load_val_i),
    .wr_hi_i    (ddp_steer(ptr_wr_hi_i, sel, 1'b0)),
    .wr_lo_i    (ddp_steer(ptr_wr_lo_i, sel, 1'b0)),
    .wdata_i    (sfr_wdata_i),
    .inc_i      (ddp_steer(ptr_inc_i, sel, 1'b0)),
    .ptr_o      (ptr0)
  );

  ddp_pointer u_ptr1 (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_reg),
    .load_i     (ddp_steer(ptr_load_i, sel, 1'b1)),
    .load_val_i (ptr_load_val_i),
    .wr_hi_i    (ddp_steer(ptr_wr_hi_i, sel, 1'b1)),
    .wr_lo_i    (ddp_steer(ptr_wr_lo_i, sel, 1'b1)),
    .wdata_i    (sfr_wdata_i),
    .inc_i      (ddp_steer(ptr_inc_i, sel, 1'b1)),
    .ptr_o      (ptr1)
  );

  // the pointer that moves and external moves use
  assign sel_ptr = sel ? ptr1 : ptr0;

  // output registers: readback, selected pointer, external address
  always_comb begin
    rdata_next = ctrl_reg;
    dp_next    = sel_ptr;
    xaddr_next = xaddr_reg;
    xval_next  = xmove_i;
    if (xmove_i) begin
      xaddr_next = sel_ptr;
    end
  end

  // output flip-flops, all zero while in reset
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= 8'h00;
      dp_reg    <= ddp_pkg::PTR_RESET;
      xaddr_reg <= ddp_pkg::PTR_RESET;
      xval_reg  <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      dp_reg    <= dp_next;
      xaddr_reg <= xaddr_next;
      xval_reg  <= xval_next;
    end
  end

  // every output straight from a register
  assign ctrl_rdata_o   = rdata_reg;
  assign data_pointer_o = dp_reg;
  assign addr_hi_o      = xaddr_reg[15:8];
  assign addr_lo_o      = xaddr_reg[7:0];
  assign addr_valid_o   = xval_reg;

  // checks on the control register
  a_stuck_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    ctrl_reg[ddp_pkg::STUCK_BIT] == 1'b0) else $error("stuck bit set");
  a_inc_toggle: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    ctrl_hit && ctrl_inc_i |=> ctrl_reg[0] != $past(ctrl_reg[0]))
    else $error("select not toggled");
  a_inc_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    ctrl_hit && ctrl_inc_i |=> ctrl_reg[3] == $past(ctrl_reg[3]))
    else $error("flag changed by increment");
  a_inc_only_sel: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    ctrl_hit && ctrl_inc_i |=> ctrl_reg[7:1] == $past(ctrl_reg[7:1]))
    else $error("increment changed more than the select");
  a_ctrl_write: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    ctrl_hit && sfr_wr_i && !ctrl_inc_i |=>
      ctrl_reg[ddp_pkg::SEL_BIT] == $past(sfr_wdata_i[ddp_pkg::SEL_BIT]) &&
      ctrl_reg[ddp_pkg::FLAG_BIT] == $past(sfr_wdata_i[ddp_pkg::FLAG_BIT]))
    else $error("control write lost");
  a_other_addr: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    !ctrl_hit |=> ctrl_reg == $past(ctrl_reg))
    else $error("control changed by another address");
  a_reset_sel: assert property (@(posedge mclk_i)
    $rose(rst_n_reg) |-> ctrl_reg[ddp_pkg::SEL_BIT] == ddp_pkg::SEL_RESET &&
      ctrl_reg[ddp_pkg::STUCK_BIT] == 1'b0) else $error("select not reset");

  // checks on the pointers and the shown pointer
  a_sel_out: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    ##1 data_pointer_o == ($past(sel) ? $past(ptr1) : $past(ptr0)))
    else $error("wrong pointer shown");
  a_hold_ptr0: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    sel |=> ptr0 == $past(ptr0)) else $error("idle pointer 0 changed");
  a_hold_ptr1: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    !sel |=> ptr1 == $past(ptr1)) else $error("idle pointer 1 changed");
  a_load_ptr: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    ptr_load_i |=> sel_ptr == $past(ptr_load_val_i) || sel != $past(sel))
    else $error("pointer load lost");
  a_wr_hi_byte: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    ptr_wr_hi_i && !ptr_load_i && !ptr_inc_i |=>
      sel_ptr[15:8] == $past(sfr_wdata_i) || sel != $past(sel))
    else $error("pointer high byte write lost");
  a_wr_lo_byte: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    ptr_wr_lo_i && !ptr_load_i && !ptr_inc_i |=>
      sel_ptr[7:0] == $past(sfr_wdata_i) || sel != $past(sel))
    else $error("pointer low byte write lost");
  a_ptr_inc: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    ptr_inc_i && !ptr_load_i |=> sel_ptr == $past(sel_ptr) + 16'h0001 || sel != $past(sel))
    else $error("pointer increment lost");

  // external move in steps: strobe taken, then the valid flag for one cycle only
  sequence s_xmove_taken;
    xmove_i;
  endsequence
  sequence s_valid_one_cycle;
    addr_valid_o ##1 (addr_valid_o == $past(xmove_i));
  endsequence
  a_xmove_addr: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    s_xmove_taken |=> addr_valid_o && {addr_hi_o, addr_lo_o} == $past(sel_ptr))
    else $error("external address wrong");
  a_valid_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    s_xmove_taken |=> s_valid_one_cycle)
    else $error("address valid not one cycle");
  a_addr_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_reg)
    !xmove_i |=> {addr_hi_o, addr_lo_o} == $past({addr_hi_o, addr_lo_o}))
    else $error("external address moved without a move");
endmodule

// [verification/ddp_core_model.sv]
// Purpose: core model issuing register and pointer commands
// Assumes: one strobe pulse per call, changed 1 ns after the edge
// Notes:   released payload lines show the inverse of the last value
`timescale 1ns/1ps
module ddp_core_model (
  // clock
  input  wire logic        mclk_i,
  // commands to the pointer unit
  output logic      [7:0]  sfr_addr_o,
  output logic             sfr_wr_o,
  output logic      [7:0]  sfr_wdata_o,
  output logic             ctrl_inc_o,
  output logic             ld_o,
  output logic      [15:0] ld_val_o,
  output logic             whi_o,
  output logic             wlo_o,
  output logic             pinc_o,
  output logic             xmv_o
);
  // idle at time zero
  initial begin
    {sfr_wr_o, ctrl_inc_o, ld_o, whi_o, wlo_o, pinc_o, xmv_o} = 7'h00;
    {sfr_addr_o, sfr_wdata_o} = 16'h0000;
    ld_val_o = 16'h0000;
  end
  // one command held across exactly one taking edge
  task automatic op(input logic [6:0] s, input logic [15:0] v);
    @(posedge mclk_i) #1;
    {sfr_wr_o, ctrl_inc_o, ld_o, whi_o, wlo_o, pinc_o, xmv_o} = s;
    {sfr_addr_o, sfr_wdata_o} = v;
    ld_val_o = v;
    @(posedge mclk_i) #1;
    {sfr_wr_o, ctrl_inc_o, ld_o, whi_o, wlo_o, pinc_o, xmv_o} = 7'h00;
    {sfr_addr_o, sfr_wdata_o} = ~v; // stale payload must not be reused
    ld_val_o = ~v;
  endtask
endmodule

// [verification/tb_top.sv]
// Purpose: self-checking bench of the dual data pointer
// Assumes: readback and pointer outputs settle two edges after a command, external address and valid one edge
// Notes:   strobe codes follow the core model's strobe order
`timescale 1ns/1ps
module tb_top;
  localparam logic [6:0] WR = 7'h40, CI = 7'h20, LD = 7'h10, WH = 7'h08, PI = 7'h02, XM = 7'h01;
  localparam logic [6:0] WL = 7'h04;
  logic        mclk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  sa, sd, crd, ahi, alo;
  logic [15:0] lv, dp;
  logic        sw, ci, ld, wh, wl, pi, xm, av;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  // clock and hang guard
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 500) begin
      err_total++;
      tally_and_finish();
    end
  end
  ddp_core_model i_core (.mclk_i(mclk_i), .sfr_addr_o(sa), .sfr_wr_o(sw), .sfr_wdata_o(sd),
    .ctrl_inc_o(ci), .ld_o(ld), .ld_val_o(lv), .whi_o(wh), .wlo_o(wl), .pinc_o(pi), .xmv_o(xm));
  ddp_dual_pointer i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .sfr_addr_i(sa), .sfr_wr_i(sw),
    .sfr_wdata_i(sd), .ctrl_inc_i(ci), .ptr_load_i(ld), .ptr_load_val_i(lv), .ptr_wr_hi_i(wh),
    .ptr_wr_lo_i(wl), .ptr_inc_i(pi), .xmove_i(xm), .ctrl_rdata_o(crd), .data_pointer_o(dp),
    .addr_hi_o(ahi), .addr_lo_o(alo), .addr_valid_o(av));
  // compare one value
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // let the outputs catch up with the last command
  task automatic step();
    @(posedge mclk_i) #1;
  endtask
  // verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge mclk_i);
    #1 arst_n_i = 1'b1;
    repeat (3) @(posedge mclk_i) #1;
    chk({14'h0, crd[2], crd[0]}, 16'h0000);
    i_core.op(LD, 16'h1234);
    i_core.op(CI, 16'ha200);
    step();
    chk({8'h00, crd}, 16'h0001);
    chk(dp, 16'h0000);
    i_core.op(LD, 16'habcd);
    i_core.op(WH, 16'h0055);
    i_core.op(PI, 16'h0000);
    step();
    chk(dp, 16'h55ce);
    i_core.op(WL, 16'h0077);
    step();
    chk(dp, 16'h5577);
    i_core.op(CI, 16'ha200);
    step();
    chk(dp, 16'h1234);
    i_core.op(XM, 16'h0000);
    chk({ahi, alo}, 16'h1234);
    chk({15'h0, av}, 16'h0001);
    step();
    chk({15'h0, av}, 16'h0000);
    i_core.op(WR, 16'ha2ff);
    step();
    chk({8'h00, crd}, 16'h00fb);
    i_core.op(WR, 16'ha309);
    step();
    chk({8'h00, crd}, 16'h00fb);
    i_core.op(WR, 16'ha209);
    i_core.op(CI, 16'ha200);
    step();
    chk({13'h0, crd[3], crd[2], crd[0]}, 16'h0004);
    chk(dp, 16'h1234);
    chk({8'h00, crd}, 16'h0008);
    i_core.op(CI, 16'ha200);
    step();
    chk({8'h00, crd}, 16'h0009);
    chk(dp, 16'h5577);
    arst_n_i = 1'b0;
    repeat (2) step();
    arst_n_i = 1'b1;
    repeat (3) step();
    chk({14'h0, crd[2], crd[0]}, 16'h0000);
    chk(dp, 16'h0000);
    i_core.op(LD, 16'h2468);
    step();
    chk(dp, 16'h2468);
    tally_and_finish();
  end
endmodule
